// ---- imdr_host.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// Host model: one access at a time
// ----------------------------------------
module imdr_host (
	output imdr_pkg::imdr_req_t req,
	input wire logic clk_sys,
	input wire logic [7:0] rdata
);
	initial req = '0;
	// Strobe held one full cycle; bus garbled after release, not left stale
	task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(negedge clk_sys);
		req = '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge clk_sys);
		req = '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: ~d};
		@(negedge clk_sys);
		q = rdata;
	endtask
endmodule

// ---- imdr_pkg.sv ----
package imdr_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [6:0] ADDR_ENABLE_LOW = 7'h43; // Lowest enable byte
	localparam logic [6:0] ADDR_ENABLE_MID = 7'h44; // Enable bits 15..8
	localparam logic [6:0] ADDR_ENABLE_HIGH = 7'h45; // Enable bits 23..16
	localparam logic [6:0] ADDR_PREDIV_LOW = 7'h46; // Divider bits 7..0
	localparam logic [6:0] ADDR_PREDIV_HIGH = 7'h47; // Divider bits 13..8

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_ENABLE = 8'h00; // All sources start disabled
	localparam logic [7:0] RST_PREDIV_LOW = 8'hff;
	localparam logic [7:0] RST_PREDIV_HIGH = 8'h3f;

	// ----------------------------------------
	// Field layout
	// ----------------------------------------
	localparam logic [7:0] MASK_ENABLE_MID = 8'hc1; // Bits 7, 6 and 0 live
	localparam logic [7:0] MASK_ENABLE_HIGH = 8'h40; // Only bit 6 lives
	localparam logic [7:0] MASK_PREDIV_HIGH = 8'h3f; // Low six bits live
	localparam int BIT_MODE_CHANGE = 15; // Word bit of mode change
	localparam int BIT_REF_LOSS = 14; // Word bit of main reference loss
	localparam int BIT_FOURTH_INPUT = 8; // Word bit of fourth_input_clock
	localparam int BIT_SECONDARY_LOOP = 22; // Word bit of secondary_loop_state

	// Host register access carried as one bundle
	typedef struct packed {
		logic wr; // Write strobe, one cycle
		logic rd; // Read strobe, one cycle
		logic [6:0] addr; // Register offset
		logic [7:0] wdata; // Write data
	} imdr_req_t;

	// Configuration handed to the rest of the device
	typedef struct packed {
		logic [23:0] enable; // Interrupt-enable word
		logic [13:0] prediv; // Input pre-divider factor
	} imdr_cfg_t;
endpackage

// ---- imdr_regs.sv ----
`timescale 1ns/1ns
// How it works
// R1: mid bit7 enables mode-change interrupt
// R2: mid bit6 enables reference-loss interrupt
// R3: mid bit0 enables fourth input interrupt
// R4: high bit6 enables secondary loop interrupt
// R5: 0x44 holds enable 15:8, reset zero
// R6: 0x45 holds enable 23:16, reset zero
// R7: 0x46 holds divider 7:0, reset ff
// R8: next register holds divider 13:8, reset 3f
// R9: preceding register holds enable bits 7:0
// R10: interrupt only while enabled flag pending
module imdr_regs (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire imdr_pkg::imdr_req_t req,
	output logic [7:0] rdata,
	input wire logic [23:0] event_pending,
	output imdr_pkg::imdr_cfg_t cfg,
	output logic irq
);
	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [7:0] enable_low; // Enable bits 7..0
	logic [7:0] enable_mid; // Enable bits 15..8
	logic [7:0] enable_high; // Enable bits 23..16
	logic [7:0] prediv_low; // Divider bits 7..0
	logic [7:0] prediv_high; // Divider bits 13..8
	logic [7:0] next_enable_low; // Low enable byte after this edge
	logic [7:0] next_enable_mid; // Mid enable byte after this edge
	logic [7:0] next_enable_high; // High enable byte after this edge
	logic [7:0] next_prediv_low; // Divider low byte after this edge
	logic [7:0] next_prediv_high; // Divider high byte after this edge
	logic [7:0] next_rdata; // Read answer after this edge
	logic [23:0] gated_events; // Pending events that pass their enable

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	// Register select, shared by every write branch
	function automatic logic hit(input imdr_pkg::imdr_req_t r, input logic [6:0] a);
		hit = (r.addr == a);
	endfunction

	// ----------------------------------------
	// Configuration next values
	// ----------------------------------------
	// Write path; unused bits are dropped on write so they always read zero
	always_comb begin
		// Default: every register keeps its value
		next_enable_low = enable_low;
		next_enable_mid = enable_mid;
		next_enable_high = enable_high;
		next_prediv_low = prediv_low;
		next_prediv_high = prediv_high;
		// Offsets outside the bank match no branch and change nothing
		if (req.wr) begin
			if (hit(req, imdr_pkg::ADDR_ENABLE_LOW)) begin
				// All eight low enables are writable
				next_enable_low = req.wdata; // see R9
			end
			if (hit(req, imdr_pkg::ADDR_ENABLE_MID)) begin
				// Keep only mode, reference loss and fourth input enables
				next_enable_mid = req.wdata & imdr_pkg::MASK_ENABLE_MID; // see R1 R2 R3 R5
			end
			if (hit(req, imdr_pkg::ADDR_ENABLE_HIGH)) begin
				// Keep only the secondary loop enable
				next_enable_high = req.wdata & imdr_pkg::MASK_ENABLE_HIGH; // see R4 R6
			end
			if (hit(req, imdr_pkg::ADDR_PREDIV_LOW)) begin
				// Whole byte of the divider is live
				next_prediv_low = req.wdata; // see R7
			end
			if (hit(req, imdr_pkg::ADDR_PREDIV_HIGH)) begin
				// Top two bits dropped so the factor stays fourteen bits
				next_prediv_high = req.wdata & imdr_pkg::MASK_PREDIV_HIGH; // see R8
			end
		end
	end

	// Registering only; synchronous reset to documented defaults
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			enable_low <= imdr_pkg::RST_ENABLE; // see R9
			enable_mid <= imdr_pkg::RST_ENABLE; // see R5
			enable_high <= imdr_pkg::RST_ENABLE; // see R6
			prediv_low <= imdr_pkg::RST_PREDIV_LOW; // see R7
			prediv_high <= imdr_pkg::RST_PREDIV_HIGH; // see R8
		end else begin
			enable_low <= next_enable_low;
			enable_mid <= next_enable_mid;
			enable_high <= next_enable_high;
			prediv_low <= next_prediv_low;
			prediv_high <= next_prediv_high;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Read mux; the answer holds between reads so a slow host may fetch it late
	always_comb begin
		// Default: hold the last answer
		next_rdata = rdata;
		if (req.rd) begin
			// Unmapped offsets answer zero
			case (req.addr)
				imdr_pkg::ADDR_ENABLE_LOW: next_rdata = enable_low;
				imdr_pkg::ADDR_ENABLE_MID: next_rdata = enable_mid;
				imdr_pkg::ADDR_ENABLE_HIGH: next_rdata = enable_high;
				imdr_pkg::ADDR_PREDIV_LOW: next_rdata = prediv_low;
				imdr_pkg::ADDR_PREDIV_HIGH: next_rdata = prediv_high;
				default: next_rdata = '0;
			endcase
		end
	end

	// Read data register; a read beside a write returns the old value
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			// Nothing read yet
			rdata <= '0;
		end else begin
			rdata <= next_rdata;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Top two divider bits are always zero, so the size cast drops nothing
	assign cfg = '{
		enable: {enable_high, enable_mid, enable_low},
		prediv: 14'({prediv_high, prediv_low})
	};

	// ----------------------------------------
	// Interrupt gating
	// ----------------------------------------
	// Each pending flag passes only through its own enable bit
	assign gated_events = event_pending & cfg.enable; // see R1 R2 R3 R4
	// Combinational gate so a cleared enable silences its source at once;
	// the price is a level that may glitch, so users sample it on the clock
	assign irq = |gated_events; // see R10

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Mode change alone follows its enable
	a_mode_gate: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R1
		(event_pending == (24'h00_0001 << imdr_pkg::BIT_MODE_CHANGE)) |->
		(irq == enable_mid[7])) else $error("mode change gate wrong");

	// Reference loss alone follows its enable
	a_refloss_gate: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R2
		(event_pending == (24'h00_0001 << imdr_pkg::BIT_REF_LOSS)) |->
		(irq == enable_mid[6])) else $error("reference loss gate wrong");

	// Fourth input alone follows its enable
	a_fourth_gate: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R3
		(event_pending == (24'h00_0001 << imdr_pkg::BIT_FOURTH_INPUT)) |->
		(irq == enable_mid[0])) else $error("fourth input gate wrong");

	// Secondary loop change alone follows its enable
	a_loop_gate: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R4
		(event_pending == (24'h00_0001 << imdr_pkg::BIT_SECONDARY_LOOP)) |->
		(irq == enable_high[6])) else $error("secondary loop gate wrong");

	// Mid enable write lands with dead bits cleared
	a_mid_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R5
		(req.wr && req.addr == imdr_pkg::ADDR_ENABLE_MID) |=>
		(cfg.enable[15:8] == ($past(req.wdata) & imdr_pkg::MASK_ENABLE_MID)))
		else $error("mid enable write lost");

	// High enable write keeps only its one live bit
	a_high_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R6
		(req.wr && req.addr == imdr_pkg::ADDR_ENABLE_HIGH) |=>
		(cfg.enable[23:16] == ($past(req.wdata) & imdr_pkg::MASK_ENABLE_HIGH)))
		else $error("high enable write lost");

	// Divider comes out of reset at its full default
	a_prediv_reset: assert property (@(posedge clk_sys) // see R7
		$past(!rst_n) |->
		(cfg.prediv == 14'({imdr_pkg::RST_PREDIV_HIGH, imdr_pkg::RST_PREDIV_LOW})))
		else $error("divider reset wrong");

	// Enables come out of reset all off
	a_enable_reset: assert property (@(posedge clk_sys) // see R5 R6
		$past(!rst_n) |-> (cfg.enable == {3{imdr_pkg::RST_ENABLE}}))
		else $error("enable reset wrong");

	// Divider high write lands in the top six bits of the factor
	a_prediv_high: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R8
		(req.wr && req.addr == imdr_pkg::ADDR_PREDIV_HIGH) |=>
		(cfg.prediv[13:8] == $past(req.wdata[5:0])) && (prediv_high[7:6] == 2'h0))
		else $error("divider high write lost");

	// Divider low write takes the whole byte
	a_prediv_low: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R7
		(req.wr && req.addr == imdr_pkg::ADDR_PREDIV_LOW) |=>
		(cfg.prediv[7:0] == $past(req.wdata))) else $error("divider low write lost");

	// Low enable write takes the whole byte
	a_low_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R9
		(req.wr && req.addr == imdr_pkg::ADDR_ENABLE_LOW) |=>
		(cfg.enable[7:0] == $past(req.wdata))) else $error("low enable write lost");

	// Low enable byte reads back what it holds
	a_low_read: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R9
		(req.rd && req.addr == imdr_pkg::ADDR_ENABLE_LOW && !req.wr) |=>
		(rdata == cfg.enable[7:0])) else $error("low enable readback wrong");

	// Mid enable byte reads back what it holds
	a_mid_read: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R5
		(req.rd && req.addr == imdr_pkg::ADDR_ENABLE_MID && !req.wr) |=>
		(rdata == cfg.enable[15:8])) else $error("mid enable readback wrong");

	// Mid enable byte never moves without a write to it
	a_mid_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R5
		!(req.wr && req.addr == imdr_pkg::ADDR_ENABLE_MID) |=> $stable(enable_mid))
		else $error("mid enable changed unasked");

	// Bits with no function always hold zero
	a_unused_zero: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R6
		((enable_mid & ~imdr_pkg::MASK_ENABLE_MID) == 8'h00) &&
		((enable_high & ~imdr_pkg::MASK_ENABLE_HIGH) == 8'h00) &&
		((prediv_high & ~imdr_pkg::MASK_PREDIV_HIGH) == 8'h00))
		else $error("unused bit set");

	// Interrupt only while some byte holds a pending flag with its enable
	a_irq_cause: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R10
		irq |-> (((event_pending[7:0] & enable_low) != 8'h00) ||
		((event_pending[15:8] & enable_mid) != 8'h00) ||
		((event_pending[23:16] & enable_high) != 8'h00))) else $error("irq without cause");

	// With every enable off nothing may reach the interrupt pin
	a_irq_off: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R10
		(cfg.enable == 24'h00_0000) |-> !irq) else $error("irq while all disabled");
endmodule

// ---- interrupt_mask_divider_regs_bench.sv ----
`timescale 1ns/1ns
module interrupt_mask_divider_regs_bench;
	logic clk_sys, rst_n, irq;
	logic [23:0] event_pending;
	logic [7:0] rdata, q;
	imdr_pkg::imdr_req_t req;
	imdr_pkg::imdr_cfg_t cfg;
	int miscompares = 0, n_checks = 0;
	// Expected reset values and writable masks, offsets 0x43..0x47
	logic [7:0] rv [5] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h3f};
	logic [7:0] mk [5] = '{8'hff, 8'hc1, 8'h40, 8'hff, 8'h3f};
	int bits [4] = '{imdr_pkg::BIT_MODE_CHANGE, imdr_pkg::BIT_REF_LOSS,
		imdr_pkg::BIT_FOURTH_INPUT, imdr_pkg::BIT_SECONDARY_LOOP};
	// Two write patterns and the words each leaves behind
	logic [7:0] pat [2] = '{8'ha5, 8'h5a};
	logic [23:0] en_exp [2] = '{24'h00_81a5, 24'h40_405a};
	logic [13:0] pd_exp [2] = '{14'h25a5, 14'h1a5a};
	imdr_host u_host (.req(req), .clk_sys(clk_sys), .rdata(rdata));
	imdr_regs u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .req(req), .rdata(rdata),
		.event_pending(event_pending), .cfg(cfg), .irq(irq));
	// ----------------------------------------
	// Clock, checking and verdict
	// ----------------------------------------
	initial begin
		clk_sys = 1'h0;
		forever #10 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks=%0d miscompares=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Reset values seen on cfg, on the read port and by readback
	task automatic t_reset();
		chk(cfg.enable, 24'h00_0000);
		chk(cfg.prediv, 14'h3fff);
		chk(rdata, 8'h00);
		for (int i = 0; i < 5; i++) begin
			u_host.acc(1'h0, imdr_pkg::ADDR_ENABLE_LOW + 7'(i), 8'h00, q);
			chk(q, rv[i]);
		end
	endtask
	// Two patterns so stuck bits cannot hide; unmapped offset ignored
	task automatic t_rw();
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 5; i++) begin
				u_host.acc(1'h1, imdr_pkg::ADDR_ENABLE_LOW + 7'(i), pat[p], q);
				u_host.acc(1'h0, imdr_pkg::ADDR_ENABLE_LOW + 7'(i), 8'h00, q);
				chk(q, pat[p] & mk[i]);
			end
			chk(cfg.enable, en_exp[p]);
			chk(cfg.prediv, pd_exp[p]);
		end
		u_host.acc(1'h1, 7'h48, 8'hff, q);
		u_host.acc(1'h0, 7'h48, 8'h00, q);
		chk(q, 8'h00);
		chk(cfg.enable, en_exp[1]);
		chk(cfg.prediv, pd_exp[1]);
	endtask
	// Each source: blocked while disabled or by other enables, passes alone
	task automatic t_irq();
		logic [6:0] a;
		logic [7:0] m;
		for (int i = 0; i < 3; i++) begin
			u_host.acc(1'h1, imdr_pkg::ADDR_ENABLE_LOW + 7'(i), 8'h00, q);
		end
		for (int i = 0; i < 4; i++) begin
			a = imdr_pkg::ADDR_ENABLE_LOW + 7'(bits[i] / 8);
			m = 8'h01 << (bits[i] % 8);
			event_pending = 24'h00_0001 << bits[i];
			@(negedge clk_sys);
			chk(irq, 1'h0);
			u_host.acc(1'h1, a, ~m, q);
			chk(irq, 1'h0);
			u_host.acc(1'h1, a, m, q);
			chk(irq, 1'h1);
			u_host.acc(1'h1, a, 8'h00, q);
			chk(irq, 1'h0);
		end
		// All enables on with nothing pending, then every flag at once
		event_pending = 24'h00_0000;
		for (int i = 0; i < 3; i++) begin
			u_host.acc(1'h1, imdr_pkg::ADDR_ENABLE_LOW + 7'(i), 8'hff, q);
		end
		chk(irq, 1'h0);
		event_pending = 24'hff_ffff;
		@(negedge clk_sys);
		chk(irq, 1'h1);
		event_pending = 24'h00_0000;
	endtask
	// Reset in mid-run brings the enables and read data back to default; the ff writes leave the divider at its default
	task automatic t_mid_reset();
		for (int i = 0; i < 5; i++) begin
			u_host.acc(1'h1, imdr_pkg::ADDR_ENABLE_LOW + 7'(i), 8'hff, q);
		end
		u_host.acc(1'h0, imdr_pkg::ADDR_PREDIV_HIGH, 8'h00, q);
		chk(q, 8'h3f);
		rst_n = 1'h0;
		repeat (2) @(negedge clk_sys);
		rst_n = 1'h1;
		chk(cfg.enable, 24'h00_0000);
		chk(cfg.prediv, 14'h3fff);
		chk(rdata, 8'h00);
		u_host.acc(1'h0, imdr_pkg::ADDR_ENABLE_MID, 8'h00, q);
		chk(q, 8'h00);
	endtask
	initial begin
		#100000;
		miscompares++;
		wrap_up();
	end
	initial begin
		rst_n = 1'h0;
		event_pending = 24'h00_0000;
		repeat (16) @(negedge clk_sys);
		rst_n = 1'h1;
		t_reset();
		t_rw();
		t_irq();
		t_mid_reset();
		wrap_up();
	end
endmodule
